// *** rtl/wdt_consts.svh ***
`ifndef WDT_CONSTS_SVH
`define WDT_CONSTS_SVH

// ----------------------------------------
// register addresses, lower 16 bits
// ----------------------------------------
`define WDT_ADDR_CTRL_WR 16'hFFA8
`define WDT_ADDR_RST_WR 16'hFFAA
`define WDT_ADDR_CTRL_RD 16'hFFA8
`define WDT_ADDR_COUNT_RD 16'hFFA9
`define WDT_ADDR_RST_RD 16'hFFAB

// ----------------------------------------
// passwords and values
// ----------------------------------------
`define WDT_PASS_COUNT 8'h5A
`define WDT_PASS_CTRL 8'hA5
`define WDT_CLEAR_DATA 8'h00
`define WDT_CTRL_RESET 8'h18
`define WDT_RST_RESET 8'h3F
`define WDT_CTRL_RSVD 8'h18
`define WDT_RST_RSVD 8'h3F

// ----------------------------------------
// field positions
// ----------------------------------------
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_ENABLE 5
`define WDT_BIT_WATCHDOG_RESET_FLAG 7
`define WDT_BIT_RESET_OUTPUT_ENABLE 6

// ----------------------------------------
// timing, in system clock states
// ----------------------------------------
`define WDT_INT_RESET_STATES 10'd518
`define WDT_EXT_RESET_STATES 10'd132

`endif

// *** rtl/wdt_pkg.sv ***
package wdt_pkg;
   typedef enum logic [1:0] {
      WDT_IDLE,
      WDT_RESETTING
   } wdt_state_type;
endpackage

// *** rtl/wdt_prescaler.sv ***
`timescale 1ns/1ns
`include "wdt_consts.svh"

module wdt_prescaler (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // control
   input wire logic run,
   input wire logic [2:0] clock_select_field,
   // tick out
   output logic tick
);
   logic [11:0] div;
   logic [11:0] mask;

   // see [RULE18]
   always_comb begin
      case (clock_select_field)
         3'h0: mask = 12'h001;
         3'h1: mask = 12'h01F;
         3'h2: mask = 12'h03F;
         3'h3: mask = 12'h07F;
         3'h4: mask = 12'h0FF;
         3'h5: mask = 12'h1FF;
         3'h6: mask = 12'h7FF;
         default: mask = 12'hFFF;
      endcase
   end

   // free divider held at zero while the counter is halted
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div <= 12'h000;
      end else if (!run) begin
         div <= 12'h000;
      end else begin
         div <= div + 12'h001;
      end
   end

   assign tick = run && ((div & mask) == mask);
endmodule

// *** rtl/wdt_top.sv ***
`timescale 1ns/1ns
`include "wdt_consts.svh"

// Behaviour
// [RULE1] counter, control and reset-control registers change only on word writes
// [RULE2] word write at shared address: 0x5A loads counter, 0xA5 loads control
// [RULE3] reset-control word 0xA5 with 0x00 clears the watchdog reset flag
// [RULE4] reset-control word with 0x5A copies data bit into reset output enable
// [RULE5] byte reads: control at FFA8, counter at FFA9, reset-control at FFAB
// [RULE6] watchdog overflow asserts chip reset for 518 states
// [RULE7] with output enable, overflow drives external reset for 132 states
// [RULE8] simultaneous pin reset and watchdog reset behaves as pin reset
// [RULE9] watchdog reset shares pin reset vector; only the flag tells them apart
// [RULE10] software rewrites the counter before overflow in watchdog mode
// [RULE11] interval mode requests an interrupt on every overflow
// [RULE12] overflow flag sets with overflow, alongside reset or interrupt
// [RULE13] watchdog reset flag sets on overflow only in enabled watchdog mode
// [RULE14] internal reset clears overflow flag but keeps watchdog reset flag
// [RULE15] interval interrupt stays asserted while overflow flag set in interval mode
// [RULE16] counter write coinciding with a tick wins, increment dropped
// [RULE17] software halts counter before changing clock select
// [RULE18] clock select picks divide by 2,32,64,128,256,512,2048,4096
// [RULE19] disabled counter held at zero; overflow is FF to 00
// [RULE20] watchdog flag and output enable reset only by the pin
// [RULE21] word writes at FFA8 for counter/control and FFAA for reset-control
// [RULE22] unmatched password leaves all registers unchanged
// [RULE23] external reset output is active low, open drain
module wdt_top (
   // clock and pin reset
   input wire logic clk,
   input wire logic reset,
   // cpu bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_write,
   input wire logic bus_read,
   input wire logic bus_word,
   input wire logic [15:0] bus_wdata,
   output logic [7:0] bus_rdata,
   // reset and interrupt
   output logic chip_reset,
   output logic external_reset_output_n,
   output logic external_reset_output_oe,
   output logic interval_interrupt
);
   logic overflow_flag;
   logic mode_select_bit;
   logic count_enable_bit;
   logic [2:0] clock_select_field;
   logic [7:0] wdog_count_value;
   logic watchdog_reset_flag;
   logic reset_output_enable;
   wdt_pkg::wdt_state_type state;
   logic [9:0] int_count;
   logic [9:0] ext_count;
   logic tick;
   logic overflow;
   logic wr_main;
   logic wr_rst;
   logic wr_count;
   logic wr_ctrl;
   logic [7:0] wdata_lo;
   logic [7:0] wdata_hi;
   logic wdog_trip;
   logic soft_reset;
   logic [7:0] next_rdata;

   // ----------------------------------------
   // write decode
   // ----------------------------------------
   assign wdata_lo = bus_wdata[7:0];
   assign wdata_hi = bus_wdata[15:8];
   // byte writes never reach these registers
   assign wr_main = bus_write && bus_word && (bus_addr == `WDT_ADDR_CTRL_WR); // see [RULE1] see [RULE21]
   assign wr_rst = bus_write && bus_word && (bus_addr == `WDT_ADDR_RST_WR); // see [RULE1] see [RULE21]
   assign wr_count = wr_main && (wdata_hi == `WDT_PASS_COUNT); // see [RULE2] see [RULE22]
   assign wr_ctrl = wr_main && (wdata_hi == `WDT_PASS_CTRL); // see [RULE2] see [RULE22]

   // ----------------------------------------
   // counter
   // ----------------------------------------
   wdt_prescaler u_prescaler (
      .clk(clk),
      .reset(soft_reset),
      .run(count_enable_bit),
      .clock_select_field(clock_select_field),
      .tick(tick)
   );

   // write wins over a coincident tick, so no overflow then
   assign overflow = tick && !wr_count && (wdog_count_value == 8'hFF); // see [RULE16] see [RULE19]
   assign wdog_trip = overflow && mode_select_bit && count_enable_bit; // see [RULE6]
   // internal reset hits everything but the pin-only bits
   assign soft_reset = reset || (state == wdt_pkg::WDT_RESETTING); // see [RULE9] see [RULE14]

   always_ff @(posedge clk or posedge soft_reset) begin
      if (soft_reset) begin
         wdog_count_value <= 8'h00;
      end else if (!count_enable_bit) begin
         wdog_count_value <= 8'h00; // see [RULE19]
      end else if (wr_count) begin
         wdog_count_value <= wdata_lo; // see [RULE2] see [RULE16]
      end else if (tick) begin
         wdog_count_value <= wdog_count_value + 8'h01;
      end
   end

   // ----------------------------------------
   // control/status register
   // ----------------------------------------
   always_ff @(posedge clk or posedge soft_reset) begin
      if (soft_reset) begin
         mode_select_bit <= 1'b0;
         count_enable_bit <= 1'b0;
         clock_select_field <= 3'h0;
      end else if (wr_ctrl) begin
         mode_select_bit <= wdata_lo[`WDT_BIT_MODE]; // see [RULE2]
         count_enable_bit <= wdata_lo[`WDT_BIT_ENABLE];
         clock_select_field <= wdata_lo[2:0];
      end
   end

   // flag: only a zero write clears; a new overflow wins over the clear
   always_ff @(posedge clk or posedge soft_reset) begin
      if (soft_reset) begin
         overflow_flag <= 1'b0; // see [RULE14]
      end else if (overflow) begin
         overflow_flag <= 1'b1; // see [RULE12]
      end else if (wr_ctrl && !wdata_lo[`WDT_BIT_OVF]) begin
         overflow_flag <= 1'b0;
      end
   end

   // ----------------------------------------
   // reset control/status, pin reset only
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         watchdog_reset_flag <= 1'b0; // see [RULE20] see [RULE8]
      end else if (wdog_trip) begin
         watchdog_reset_flag <= 1'b1; // see [RULE13]
      end else if (wr_rst && wdata_hi == `WDT_PASS_CTRL && wdata_lo == `WDT_CLEAR_DATA) begin
         watchdog_reset_flag <= 1'b0; // see [RULE3]
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reset_output_enable <= 1'b0; // see [RULE20]
      end else if (wr_rst && wdata_hi == `WDT_PASS_COUNT) begin
         reset_output_enable <= wdata_lo[`WDT_BIT_RESET_OUTPUT_ENABLE]; // see [RULE4]
      end
   end

   // ----------------------------------------
   // watchdog reset sequencer
   // ----------------------------------------
   // pin reset aborts any watchdog pulse, giving the pin priority
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state <= wdt_pkg::WDT_IDLE; // see [RULE8]
         int_count <= 10'd0;
         ext_count <= 10'd0;
      end else begin
         case (state)
            wdt_pkg::WDT_IDLE: begin
               if (wdog_trip) begin
                  state <= wdt_pkg::WDT_RESETTING;
                  int_count <= `WDT_INT_RESET_STATES - 10'd1;
                  ext_count <= reset_output_enable ? `WDT_EXT_RESET_STATES - 10'd1 : 10'd0; // see [RULE7]
               end
            end
            wdt_pkg::WDT_RESETTING: begin
               if (int_count == 10'd0) begin
                  state <= wdt_pkg::WDT_IDLE;
               end else begin
                  int_count <= int_count - 10'd1; // see [RULE6]
               end
               if (ext_count != 10'd0) begin
                  ext_count <= ext_count - 10'd1;
               end
            end
            default: begin
               state <= wdt_pkg::WDT_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         chip_reset <= 1'b0;
         external_reset_output_n <= 1'b1;
         external_reset_output_oe <= 1'b0;
      end else begin
         // one extra state registered; chip_reset spans 518 cycles
         chip_reset <= wdog_trip || (state == wdt_pkg::WDT_RESETTING && int_count != 10'd0); // see [RULE6]
         // low while driving, otherwise released
         // ext_count still nonzero on its last state, so the pin spans the full 132 states
         external_reset_output_n <= !((wdog_trip && reset_output_enable) || (ext_count != 10'd0)); // see [RULE23]
         external_reset_output_oe <= (wdog_trip && reset_output_enable) || (ext_count != 10'd0); // see [RULE7]
      end
   end

   always_ff @(posedge clk or posedge soft_reset) begin
      if (soft_reset) begin
         interval_interrupt <= 1'b0;
      end else begin
         interval_interrupt <= (overflow_flag || overflow) && !mode_select_bit; // see [RULE11] see [RULE15]
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------
   always_comb begin
      next_rdata = 8'h00;
      case (bus_addr)
         `WDT_ADDR_CTRL_RD: next_rdata = {overflow_flag, mode_select_bit, count_enable_bit, 2'b11,
                                          clock_select_field}; // see [RULE5]
         `WDT_ADDR_COUNT_RD: next_rdata = wdog_count_value;
         `WDT_ADDR_RST_RD: next_rdata = {watchdog_reset_flag, reset_output_enable, 6'h3F};
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         bus_rdata <= 8'h00;
      end else if (bus_read) begin
         bus_rdata <= next_rdata;
      end
   end
endmodule

// *** verification/watchdog_interval_timer_bench.sv ***
`timescale 1ns/1ns
module watchdog_interval_timer_bench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [15:0] bus_addr = 16'h0000;
   logic [15:0] bus_wdata = 16'h0000;
   logic bus_write = 1'b0;
   logic bus_read = 1'b0;
   logic bus_word = 1'b0;
   logic [7:0] bus_rdata;
   logic chip_reset, external_reset_output_n, external_reset_output_oe, interval_interrupt, pin;
   logic [15:0] exp_q[$];
   logic rd_d = 1'b0;
   logic rst_seen = 1'b0;
   logic [31:0] lfsr = 32'h9A203241;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int t0;
   int dv[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};
   initial forever #20 clk = ~clk;
   wdt_top dut_u (.clk, .reset, .bus_addr, .bus_write, .bus_read, .bus_word, .bus_wdata, .bus_rdata,
      .chip_reset, .external_reset_output_n, .external_reset_output_oe, .interval_interrupt);
   wdt_reset_line line_u (.oe(external_reset_output_oe), .out_n(external_reset_output_n), .pin);
   // ----------------------------------------
   // tasks and scoreboard
   // ----------------------------------------
   task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic summarize;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // idle cycle after each strobe, so no strobe is assigned twice in a step
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
      bus_addr <= a;
      bus_wdata <= d;
      bus_word <= w;
      bus_write <= 1'b1;
      @(posedge clk);
      bus_write <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back({8'h00, e});
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge clk);
      bus_read <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      rd_d <= bus_read;
      if (chip_reset === 1'b1)
         rst_seen <= 1'b1;
      if (rd_d === 1'b1)
         check("rdata", {8'h00, bus_rdata}, exp_q.pop_front());
      if (cyc == 40000) begin
         err_count++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      rd(16'hFFA8, 8'h18);
      rd(16'hFFA9, 8'h00);
      rd(16'hFFAB, 8'h3F);
      rd(16'hFFAA, 8'h00);
      wr(16'hFFA8, 16'hA53F, 1'b0);
      rd(16'hFFA8, 8'h18);
      wr(16'hFFA8, 16'h1234, 1'b1);
      rd(16'hFFA8, 8'h18);
      wr(16'hFFA8, 16'hA527, 1'b1);
      rd(16'hFFA8, 8'h3F);
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         wr(16'hFFA8, {8'h5A, lfsr[7:0]}, 1'b1);
         rd(16'hFFA9, lfsr[7:0]);
      end
      wr(16'hFFA8, 16'hA507, 1'b1);
      rd(16'hFFA9, 8'h00);
      $display("end of register test");
      for (int c = 0; c < 8; c++) begin
         wr(16'hFFA8, 16'hA500, 1'b1);
         wr(16'hFFA8, {8'hA5, 5'h04, c[2:0]}, 1'b1);
         wr(16'hFFA8, 16'h5AFF, 1'b1);
         repeat (5000) if (interval_interrupt !== 1'b1) @(posedge clk);
         t0 = cyc;
         wr(16'hFFA8, {8'hA5, 5'h04, c[2:0]}, 1'b1);
         wr(16'hFFA8, 16'h5AFF, 1'b1);
         repeat (5000) if (interval_interrupt !== 1'b1) @(posedge clk);
         check("period", 16'(cyc - t0), 16'((c == 0) ? 6 : dv[c]));
      end
      rd(16'hFFA8, 8'hBF);
      wr(16'hFFA8, 16'hA500, 1'b1);
      // the request is registered, so it drops one edge after the flag clears
      @(posedge clk);
      check("irq", interval_interrupt, 16'h0000);
      $display("end of interval test");
      wr(16'hFFAA, 16'h5A40, 1'b1);
      rd(16'hFFAB, 8'h7F);
      wr(16'hFFA8, 16'hA560, 1'b1);
      repeat (8) begin
         repeat (200) @(posedge clk);
         wr(16'hFFA8, 16'h5A00, 1'b1);
      end
      check("kicked", rst_seen, 16'h0000);
      repeat (600) if (chip_reset !== 1'b1) @(posedge clk);
      check("pin", pin, 16'h0000);
      rd(16'hFFAB, 8'hFF);
      rd(16'hFFA8, 8'h18);
      repeat (600) if (chip_reset !== 1'b0) @(posedge clk);
      wr(16'hFFAA, 16'hA500, 1'b0);
      rd(16'hFFAB, 8'hFF);
      wr(16'hFFAA, 16'hA500, 1'b1);
      rd(16'hFFAB, 8'h7F);
      wr(16'hFFAA, 16'h5A00, 1'b1);
      wr(16'hFFA8, 16'hA560, 1'b1);
      repeat (600) if (chip_reset !== 1'b1) @(posedge clk);
      check("pin", pin, 16'h0001);
      reset <= 1'b1;
      @(posedge clk);
      reset <= 1'b0;
      rd(16'hFFAB, 8'h3F);
      check("reset", chip_reset, 16'h0000);
      $display("end of watchdog test");
      summarize();
   end
endmodule

// *** verification/wdt_reset_line.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// reset line, pulled up when released
// ----------------------------------------
module wdt_reset_line (
   // drive
   input wire logic oe,
   input wire logic out_n,
   // pin
   output logic pin
);
   assign pin = oe ? out_n : 1'b1;
endmodule

// *** verification/wdt_top_chk.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// port checker
// ----------------------------------------
module wdt_chk (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // bus
   input wire logic [15:0] bus_addr,
   input wire logic bus_read,
   input wire logic [7:0] bus_rdata,
   // outputs
   input wire logic chip_reset,
   input wire logic external_reset_output_n,
   input wire logic external_reset_output_oe,
   input wire logic interval_interrupt
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   logic [9:0] rst_len;
   logic [9:0] oe_len;
   wire logic rd_ctrl = bus_read && bus_addr == 16'hFFA8;
   // counters, since 518 is too long to unroll
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rst_len <= 10'h000;
         oe_len <= 10'h000;
      end else begin
         rst_len <= chip_reset ? rst_len + 10'h001 : 10'h000;
         oe_len <= external_reset_output_oe ? oe_len + 10'h001 : 10'h000;
      end
   end
   rst_len_a: assert property ($fell(chip_reset) |-> rst_len == 10'h206) else $error("reset len");
   oe_len_a: assert property ($fell(external_reset_output_oe) |-> oe_len == 10'h084) else $error("pin len");
   oe_start_a: assert property ($rose(external_reset_output_oe) |-> $rose(chip_reset)) else $error("pin");
   pin_level_a: assert property (external_reset_output_n == !external_reset_output_oe) else $error("pin");
   irq_mode_a: assert property (!(interval_interrupt && chip_reset)) else $error("irq");
   ctrl_read_a: assert property (rd_ctrl |=> bus_rdata[4:3] == 2'b11) else $error("ctrl");
   rst_read_a: assert property (bus_read && bus_addr == 16'hFFAB |=> bus_rdata[5:0] == 6'h3F) else $error("rst");
   irq_flag_a: assert property (rd_ctrl && interval_interrupt |=> bus_rdata[7]) else $error("flag");
   ctrl_clear_a: assert property (rd_ctrl && chip_reset && $past(chip_reset) |=> bus_rdata == 8'h18)
      else $error("ctrl kept");
   cover property ($rose(chip_reset));
   cover property ($rose(external_reset_output_oe));
   cover property ($rose(interval_interrupt));
endmodule
bind wdt_top wdt_chk chk_u (.clk, .reset, .bus_addr, .bus_read, .bus_rdata, .chip_reset,
   .external_reset_output_n, .external_reset_output_oe, .interval_interrupt);
